// [test/ethernet_wakeup_frame_filter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module ethernet_wakeup_frame_filter_bench;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, mc;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, rx_data, off [0:3];
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q, bank [0:7];
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, rx_sof, rx_valid, rx_eof, rx_multicast;
  logic rx_dest_pass, rx_sync_wake, sleep_mode, power_mode_irq;
  int n_mismatch = 0, check_count = 0, seed;
  wake_frame_filter u_dut (.ref_clk, .rst_n, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_multicast,
    .rx_dest_pass, .rx_sync_wake, .sleep_mode, .power_mode_irq);
  rx_mac_model u_mac (.ref_clk, .rx_sof, .rx_valid, .rx_data, .rx_eof,
    .rx_multicast, .rx_dest_pass, .rx_sync_wake);
  initial forever #20 ref_clk = ~ref_clk; // 25 MHz
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One bus transfer; q takes the read data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge ref_clk);
    {avs_write, avs_read, avs_address, avs_writedata} <= {wr, ~wr, a, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
    @(negedge ref_clk);
    if (k >= 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Frame, then sleep state one cycle after its end
  task automatic frame(input logic m, dp, slow, input logic [31:0] exp);
    u_mac.send(m, dp, slow);
    @(negedge ref_clk);
    check("sleep", 32'(sleep_mode), exp);
  endtask
  // Reference CRC-16, MSB first, over masked bytes
  function automatic logic [15:0] crc16(input int o, input logic [31:0] m);
    logic [15:0] c = 16'hFFFF;
    for (int j = 0; j < 31; j++)
      for (int b = 7; b >= 0; b--)
        if (m[j]) c = {c[14:0], 1'b0} ^
          ((c[15] ^ u_mac.fbuf[o + j][b]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  initial begin
    seed = $urandom(45);
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 8'h2C; a <= 8'h3C; a += 4) begin
      bus(1'b0, a[7:0], 32'h0000_0000);
      check("reset", q, 32'h0000_0000);
    end
    $display("reset test done");
    // Only filter f enabled in the frame's class
    for (int f = 0; f < 4; f++) begin
      mc = f[0];
      foreach (u_mac.fbuf[i]) u_mac.fbuf[i] = 8'($urandom);
      for (int g = 0; g < 4; g++) begin
        off[g] = 8'(13 + $urandom % 5);
        bank[g] = $urandom & 32'h7FFF_FFFF | 32'h0000_0001;
        bank[4][8*g +: 8] = {4'h0, (g == f) ? {mc, 3'b001} :
          (g[0] == mc) ? {mc, 3'b000} : {~mc, 3'b001}};
        bank[5][8*g +: 8] = off[g];
        bank[6 + g/2][16*(g%2) +: 16] = crc16(off[g], bank[g]);
      end
      bus(1'b1, 8'h30, 32'h0000_0000);
      for (int w = 0; w < 8; w++)
        bus(1'b1, 8'h28, bank[w] | (w < 4 ? 32'h8000_0000 : 32'h0000_0000));
      for (int w = 0; w < 8; w++) begin
        bus(1'b1, 8'h30, 32'(w));
        bus(1'b0, 8'h28, 32'h0000_0000);
        check("bank", q, bank[w]);
      end
      bus(1'b1, 8'h38, 32'(f[1]));
      bus(1'b1, 8'h2C, 32'h0000_0001);
      check("asleep", 32'(sleep_mode), 32'h0000_0001);
      frame(mc, 1'b0, f[0], 32'h0000_0001);
      u_mac.fbuf[off[f]] ^= 8'h01;
      frame(mc, 1'b1, f[0], 32'h0000_0001);
      u_mac.fbuf[off[f]] ^= 8'h01;
      frame(mc, 1'b1, f[0], 32'h0000_0000);
      bus(1'b0, 8'h2C, 32'h0000_0000);
      check("status", q, 32'h0000_0041);
      check("irq", 32'(power_mode_irq), 32'(f[1]));
      bus(1'b1, 8'h2C, 32'h0000_0040);
      bus(1'b1, 8'h38, 32'h0000_0002);
      check("irq clear", 32'(power_mode_irq), 32'h0000_0000);
      $display("filter %0d test done", f);
    end
    bus(1'b1, 8'h30, 32'h0000_0100);
    bus(1'b1, 8'h2C, 32'h0000_0001);
    frame(mc, 1'b0, 1'b0, 32'h0000_0000);
    bus(1'b1, 8'h2C, 32'h0000_0041);
    u_mac.sync_pulse();
    @(negedge ref_clk);
    check("sync off", 32'(sleep_mode), 32'h0000_0001);
    bus(1'b1, 8'h2C, 32'h0000_0003);
    u_mac.sync_pulse();
    bus(1'b0, 8'h2C, 32'h0000_0000);
    check("sync wake", q, 32'h0000_0023);
    bus(1'b1, 8'h2C, 32'h0000_0020);
    bus(1'b1, 8'h34, 32'h0000_000C);
    bus(1'b0, 8'h34, 32'h0000_0000);
    check("cmd sleep", 32'({q[0], sleep_mode}), 32'h0000_0003);
    bus(1'b1, 8'h34, 32'h0000_000D);
    check("cmd wake", 32'(sleep_mode), 32'h0000_0000);
    $display("wake source tests done");
    stop_test();
  end
endmodule // ethernet_wakeup_frame_filter_bench
`default_nettype wire

// [test/rx_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
// MAC receive side: frame bytes, then status with end
module rx_mac_model (
  input  wire logic       ref_clk,
  output var  logic       rx_sof,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       rx_eof,
  output var  logic       rx_multicast,
  output var  logic       rx_dest_pass,
  output var  logic       rx_sync_wake
);
  logic [7:0] fbuf [0:47]; // Frame bytes, set by bench
  initial {rx_sof, rx_valid, rx_data, rx_eof, rx_multicast, rx_dest_pass,
    rx_sync_wake} = 14'h0000;
  // Slow inserts an idle cycle after every byte
  task automatic send(input logic mc, dp, slow);
    @(posedge ref_clk);
    for (int i = 0; i < 48; i++) begin
      {rx_sof, rx_valid, rx_data} <= {i == 0, 1'b1, fbuf[i]};
      @(posedge ref_clk);
      if (slow) begin
        {rx_sof, rx_valid, rx_data} <= {2'b00, ~fbuf[i]}; // No stale byte
        @(posedge ref_clk);
      end
    end
    {rx_sof, rx_valid, rx_data, rx_eof} <= {2'b00, ~fbuf[47], 1'b1};
    {rx_multicast, rx_dest_pass} <= {mc, dp};
    @(posedge ref_clk);
    {rx_eof, rx_multicast, rx_dest_pass} <= {1'b0, ~mc, ~dp};
  endtask
  // One-cycle sync-pattern indication
  task automatic sync_pulse;
    @(posedge ref_clk);
    rx_sync_wake <= 1'b1;
    @(posedge ref_clk);
    rx_sync_wake <= 1'b0;
  endtask
endmodule // rx_mac_model
`default_nettype wire

// [test/wake_filter_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Bus timing and wake-event causes seen at the ports
module wake_filter_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_eof,
  input wire logic        rx_sync_wake,
  input wire logic        sleep_mode,
  input wire logic        power_mode_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire acc = avs_write & ~avs_waitrequest; // Write taken
  wait_one_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait length");
  idle_wait_a: assert property (!(avs_read | avs_write) |->
    !avs_waitrequest) else $error("idle stall");
  read_hold_a: assert property (!avs_read |=>
    $stable(avs_readdata)) else $error("read data moved");
  sleep_cause_a: assert property ($rose(sleep_mode) |->
    $past(acc)) else $error("sleep without write");
  wake_cause_a: assert property ($fell(sleep_mode) |->
    $past(rx_eof | rx_sync_wake | acc)) else $error("wake without cause");
  irq_cause_a: assert property ($rose(power_mode_irq) |->
    $past(rx_eof | rx_sync_wake) && $past(sleep_mode)) else $error("irq cause");
  irq_wake_a: assert property ($rose(power_mode_irq) |->
    $fell(sleep_mode)) else $error("irq without wake");
  irq_sticky_a: assert property (power_mode_irq &&
    !(acc && avs_address == 8'h38) |=> power_mode_irq) else $error("irq lost");
  cover property ($fell(sleep_mode));
  cover property ($rose(power_mode_irq));
  cover property (rx_sync_wake && sleep_mode);
endmodule // wake_filter_chk
bind wake_frame_filter wake_filter_chk u_chk (.ref_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .rx_eof,
  .rx_sync_wake, .sleep_mode, .power_mode_irq);
`default_nettype wire

// [verilog/wake_filter_consts.vh]
`ifndef WAKE_FILTER_CONSTS_VH
`define WAKE_FILTER_CONSTS_VH
// Register byte addresses
`define OFS_FILTER_BANK   8'h28
`define OFS_WAKE_CTRL     8'h2C
`define OFS_FILTER_SEL    8'h30
`define OFS_SLEEP_CMD     8'h34
`define OFS_IRQ_CTRL      8'h38
// Filter bank word indices
`define BANK_MASK0        3'd0
`define BANK_CMD          3'd4
`define BANK_OFFSET       3'd5
`define BANK_CRC01        3'd6
`define BANK_CRC23        3'd7
// Command nibble fields
`define CMD_ENABLE_BIT    0
`define CMD_MCAST_BIT     3
// Wake control register fields
`define WAKE_PATTERN_EN   0
`define WAKE_SYNC_EN      1
`define WAKE_SYNC_RCVD    5
`define WAKE_PATTERN_RCVD 6
`define WAKE_SLEEPING     7
// Interrupt control fields
`define IRQ_ENABLE_BIT    0
`define IRQ_FLAG_BIT      1
// Sleep commands
`define CMD_SLEEP_ON      4'hC
`define CMD_SLEEP_OFF     4'hD
// Mask width and CRC seed
`define MASK_LAST_BIT     31
`define CRC16_SEED        16'hFFFF
`define CRC16_POLY        16'h8005
`define RESET_WORD        32'h0000_0000
`endif

// [verilog/wake_frame_filter.v]
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "wake_filter_consts.vh"

// Register map, byte addresses on the bus
//   28h  filter bank window, word picked by pointer
//   2Ch  wake control and status
//   30h  bank pointer and destination bypass
//   34h  sleep command
//   38h  interrupt enable and flag
// Filter bank words
//   0..3  byte masks of filters 0 to 3
//   4     command nibbles, one byte per filter
//   5     offsets, one byte per filter
//   6     CRC of filters 0 and 1, filter 0 low
//   7     CRC of filters 2 and 3, filter 2 low
// Bank window
//   Pointer advances after each write
//   Reads leave the pointer alone
//   Byte enables merge partial writes
//   Mask bit 31 cleared on every mask write
// Wake control bits
//   0  pattern wake enable
//   1  sync wake enable
//   5  sync frame received, write one clears
//   6  pattern frame received, write one clears
//   7  sleeping, read only
// Pointer register bits
//   2:0  bank word pointer
//   8    destination filter bypass
// Sleep command codes
//   Ch  enter sleep by command
//   Dh  leave sleep entered by command
//   Read bit 0 shows sleep by command
// Interrupt register bits
//   0  interrupt enable
//   1  flag, write one clears
// Bus timing
//   One wait cycle on every request
//   Write lands on the second request edge
//   Read data registered on the first edge
//   Read data held until the next read
// Frame timing
//   Byte 0 arrives with the start strobe
//   End strobe follows the last byte
//   Frame class and address result sampled at end
//   Sync indication taken on any cycle with sync wake enabled, only at frame end for command sleep
// CRC
//   CRC-16, polynomial 8005, seed FFFF
//   Bytes fed most significant bit first
//   Each filter keeps its own running value
// Wake decisions
//   Events win over same-cycle clears
//   Enables survive a wake, sleeping clears
//   Sleep by enables ignores wake command
//   Flag cleared only by software
// Clock enable
//   Low freezes every register
//   Bus answer waits while frozen at the first request edge
// Reset
//   Synchronous, active low
//   Clears bank, controls and flags
//   Outputs low after release
// Limits
//   Frames longer than 2048 bytes wrap index
//   Offsets below 13 not rejected by hardware
//   Unmapped addresses read as zero
//   Unmapped writes ignored
// Frame class
//   Multicast selector in command bit 3
//   Enable in command bit 0
//   Upper nibble of each command byte reserved

// Functional notes
// RULE1 - Sync-pattern and pattern frames can wake
// RULE2 - Class wakes only when software enables it; command sleep also ends on pattern or sync frames without enables
// RULE3 - Any of four filters matching means wake
// RULE4 - Bypass clear requires destination filter pass
// RULE5 - Filter has command, offset, mask, CRC
// RULE6 - Command MSB picks unicast or multicast frames
// RULE7 - Command LSB enables filter; disabled never matches
// RULE8 - Offset gives first examined frame byte
// RULE9 - Software keeps offsets above twelve
// RULE10 - Masked bytes at offset plus j feed CRC
// RULE11 - Mask bit 31 always zero
// RULE12 - Match when CRC equals stored value
// RULE13 - Pattern wake sets status bit 6
// RULE14 - Interrupt only when irq enable set
// RULE15 - Offsets packed one byte per filter
// RULE16 - Command 1100b puts controller asleep
// RULE17 - Enable bits at 2Ch; enabling sleeps
// RULE18 - Wake exit depends on how sleep entered
// RULE19 - Irq flag cleared only by software
// RULE20 - Bank is eight words in fixed order
// RULE21 - Command nibble low in each byte
module wake_frame_filter #(
  parameter NUM_FILTERS = 4
) (
  input  wire        ref_clk,           // Controller clock
  input  wire        rst_n,             // Synchronous reset, active low
  input  wire        clk_en,            // Freezes all state when low
  input  wire [7:0]  avs_address,       // Byte address
  input  wire        avs_read,          // Read request
  input  wire        avs_write,         // Write request
  input  wire [31:0] avs_writedata,     // Write data
  input  wire [3:0]  avs_byteenable,    // Byte lanes
  output reg  [31:0] avs_readdata,      // Read data
  output wire        avs_waitrequest,   // Stall
  input  wire        rx_sof,            // First byte of a frame
  input  wire        rx_valid,          // Byte strobe
  input  wire [7:0]  rx_data,           // Frame byte
  input  wire        rx_eof,            // Frame end with status
  input  wire        rx_multicast,      // Frame destination multicast
  input  wire        rx_dest_pass,      // Destination filter passed
  input  wire        rx_sync_wake,      // Sync-pattern frame seen
  output wire        sleep_mode,        // Controller asleep
  output wire        power_mode_irq     // Interrupt request
);

  // Filter bank storage, eight words
  reg  [31:0] bank_reg [0:7];           // [RULE20]
  reg  [7:0]  wake_ctrl_reg;            // Enables and status
  reg         dest_filter_bypass_reg;   // Destination bypass
  reg         power_mode_irq_enable_reg;
  reg         power_mode_irq_flag_reg;
  reg         sleep_by_cmd_reg;         // Sleep entered by command
  reg         ack_reg;                  // One-cycle answer
  reg  [15:0] crc_reg [0:3];            // Running CRC per filter
  reg  [10:0] byte_pos_reg;             // Byte index in frame
  reg         in_frame_reg;             // Frame in progress
  integer     i;                        // Loop index, CRC process
  integer     j;                        // Loop index, register process

  // CRC-16 update over one byte, MSB first
  function [15:0] crc16_byte;
    input [15:0] crc_in;
    input [7:0]  data;
    integer k;
    reg [15:0] c;
    begin
      c = crc_in;
      for (k = 7; k >= 0; k = k - 1) begin
        if (c[15] ^ data[k])
          c = {c[14:0], 1'b0} ^ `CRC16_POLY;
        else
          c = {c[14:0], 1'b0};
      end
      crc16_byte = c;
    end
  endfunction

  // True when a frame byte feeds one filter's CRC
  function feeds_crc;
    input [10:0] pos;                   // Byte index in frame
    input [7:0]  ofs;                   // Filter offset
    input [31:0] mask;                  // Filter byte mask
    reg   [10:0] rel;                   // Index relative to offset
    begin
      rel = pos - {3'b000, ofs};
      // Window is offset through offset plus 30
      if (pos >= {3'b000, ofs} && rel < 11'd31)
        feeds_crc = mask[rel[4:0]];                         // [RULE10]
      else
        feeds_crc = 1'b0;
    end
  endfunction

  // Byte-lane merge of a write
  function [31:0] merge_be;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  be;
    integer b;
    begin
      merge_be = old_w;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b])
          merge_be[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
  endfunction

  // Bank word pointer for the 28h window
  reg  [2:0]  bank_ptr_reg;
  wire        access = avs_read | avs_write;
  // Answer the cycle after a request
  assign avs_waitrequest = access & ~ack_reg;
  wire        wr_go = avs_write & ack_reg & clk_en;
  wire        sleeping = wake_ctrl_reg[`WAKE_SLEEPING];
  // Index of the byte now on the link
  wire [10:0] cur_pos = rx_sof ? 11'h000 : byte_pos_reg;

  // Per-filter view of the bank
  wire [3:0]  f_en;
  wire [3:0]  f_hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_f
      wire [3:0]  cmd  = bank_reg[`BANK_CMD][g*8 +: 4];     // [RULE21]
      wire [7:0]  ofs  = bank_reg[`BANK_OFFSET][g*8 +: 8];  // [RULE15]
      // Each filter: command, offset, mask, CRC         // [RULE5]
      wire [15:0] want = bank_reg[`BANK_CRC01 + g/2][(g%2)*16 +: 16];
      // Frame class must match selector bit
      assign f_en[g] = cmd[`CMD_ENABLE_BIT] &                // [RULE7]
        (cmd[`CMD_MCAST_BIT] == rx_multicast);               // [RULE6]
      assign f_hit[g] = f_en[g] & (crc_reg[g] == want);      // [RULE12]
    end
  endgenerate

  // Pattern wake decision at frame end
  wire pattern_hit = (|f_hit) &                              // [RULE3]
    (dest_filter_bypass_reg | rx_dest_pass);                 // [RULE4]
  wire pat_wake = sleeping & wake_ctrl_reg[`WAKE_PATTERN_EN] &
    rx_eof & in_frame_reg & pattern_hit;                     // [RULE2]
  wire syn_wake = sleeping & wake_ctrl_reg[`WAKE_SYNC_EN] &
    rx_sync_wake;                                            // [RULE1]
  // Command sleep also ends on either frame type
  wire cmd_any = sleeping & sleep_by_cmd_reg & rx_eof &
    in_frame_reg & (pattern_hit | rx_sync_wake);             // [RULE18]
  wire wake_evt = pat_wake | syn_wake | cmd_any;

  // Per-filter CRC accumulation
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      in_frame_reg <= 1'b0;
      byte_pos_reg <= 11'h000;
      for (i = 0; i < 4; i = i + 1)
        crc_reg[i] <= `CRC16_SEED;
    end else if (clk_en) begin
      if (rx_sof) begin
        in_frame_reg <= 1'b1;
        byte_pos_reg <= 11'h000;
        for (i = 0; i < 4; i = i + 1)
          crc_reg[i] <= `CRC16_SEED;
      end else if (rx_eof) begin
        in_frame_reg <= 1'b0;
      end
      if (rx_valid & (in_frame_reg | rx_sof)) begin
        byte_pos_reg <= rx_sof ? 11'h001 : byte_pos_reg + 11'h001;
        for (i = 0; i < 4; i = i + 1) begin
          // Byte within offset..offset+30 with mask bit set
          if (feeds_crc(cur_pos,                                   // [RULE8]
                        bank_reg[`BANK_OFFSET][i*8 +: 8],
                        bank_reg[i]))                              // [RULE10]
            crc_reg[i] <= crc16_byte(rx_sof ? `CRC16_SEED : crc_reg[i],
                                     rx_data);
        end
      end
    end
  end

  // Register writes, sleep and flag control
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      for (j = 0; j < 8; j = j + 1)
        bank_reg[j] <= `RESET_WORD;
      bank_ptr_reg <= 3'd0;
      wake_ctrl_reg <= 8'h00;
      dest_filter_bypass_reg <= 1'b0;
      power_mode_irq_enable_reg <= 1'b0;
      power_mode_irq_flag_reg <= 1'b0;
      sleep_by_cmd_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= access & ~ack_reg;
      if (wr_go) begin
        case (avs_address)
          `OFS_FILTER_BANK: begin
            bank_reg[bank_ptr_reg] <= merge_be(bank_reg[bank_ptr_reg],
              avs_writedata, avs_byteenable);
            bank_ptr_reg <= bank_ptr_reg + 3'd1;
            // Mask top bit forced clear
            if (bank_ptr_reg < `BANK_CMD)
              bank_reg[bank_ptr_reg][`MASK_LAST_BIT] <= 1'b0; // [RULE11]
          end
          `OFS_FILTER_SEL: begin
            bank_ptr_reg <= avs_writedata[2:0];
            dest_filter_bypass_reg <= avs_writedata[8];
          end
          `OFS_WAKE_CTRL: begin
            wake_ctrl_reg[1:0] <= avs_writedata[1:0];
            // Writing one clears received bits
            if (avs_writedata[`WAKE_SYNC_RCVD])
              wake_ctrl_reg[`WAKE_SYNC_RCVD] <= 1'b0;
            if (avs_writedata[`WAKE_PATTERN_RCVD])
              wake_ctrl_reg[`WAKE_PATTERN_RCVD] <= 1'b0;
            // Enabling a source puts the controller asleep
            if (|avs_writedata[1:0])
              wake_ctrl_reg[`WAKE_SLEEPING] <= 1'b1;          // [RULE17]
          end
          `OFS_SLEEP_CMD: begin
            if (avs_writedata[3:0] == `CMD_SLEEP_ON) begin    // [RULE16]
              wake_ctrl_reg[`WAKE_SLEEPING] <= 1'b1;
              sleep_by_cmd_reg <= 1'b1;
            end else if (avs_writedata[3:0] == `CMD_SLEEP_OFF &&
                         sleep_by_cmd_reg) begin              // [RULE18]
              wake_ctrl_reg[`WAKE_SLEEPING] <= 1'b0;
              sleep_by_cmd_reg <= 1'b0;
            end
          end
          `OFS_IRQ_CTRL: begin
            power_mode_irq_enable_reg <= avs_writedata[`IRQ_ENABLE_BIT];
            // Software-only clear
            if (avs_writedata[`IRQ_FLAG_BIT])
              power_mode_irq_flag_reg <= 1'b0;                // [RULE19]
          end
          default: begin
          end
        endcase
      end
      // Events win over clears
      if (wake_evt) begin
        wake_ctrl_reg[`WAKE_SLEEPING] <= 1'b0;
        sleep_by_cmd_reg <= 1'b0;
        if (power_mode_irq_enable_reg)
          power_mode_irq_flag_reg <= 1'b1;                    // [RULE14]
      end
      if (pat_wake | (cmd_any & pattern_hit))
        wake_ctrl_reg[`WAKE_PATTERN_RCVD] <= 1'b1;            // [RULE13]
      if (syn_wake | (cmd_any & rx_sync_wake))
        wake_ctrl_reg[`WAKE_SYNC_RCVD] <= 1'b1;
    end
  end

  // Read data register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en & avs_read & ~ack_reg) begin
      case (avs_address)
        `OFS_FILTER_BANK: avs_readdata <= bank_reg[bank_ptr_reg];
        `OFS_FILTER_SEL:
          avs_readdata <= {23'h00_0000, dest_filter_bypass_reg,
                           5'h00, bank_ptr_reg};
        `OFS_WAKE_CTRL:   avs_readdata <= {24'h00_0000, wake_ctrl_reg};
        `OFS_SLEEP_CMD:
          avs_readdata <= {31'h0000_0000, sleep_by_cmd_reg};
        `OFS_IRQ_CTRL:
          avs_readdata <= {30'h0000_0000, power_mode_irq_flag_reg,
                           power_mode_irq_enable_reg};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign sleep_mode     = sleeping;
  assign power_mode_irq = power_mode_irq_flag_reg;

endmodule // wake_frame_filter
`default_nettype wire
